// >>> hw/ies_pkg.sv
// constants and types shared by the interrupt encoder and slip logic
package ies_pkg;

  // coded sources, index order is priority order (0 highest)
  localparam int NSRC = 10;
  localparam int SRC_RTC = 0;
  localparam int SRC_TIMER = 1;
  localparam int SRC_DPA = 2;
  localparam int SRC_DPB = 3;
  localparam int SRC_DPC = 4;
  localparam int SRC_BVR = 5;
  localparam int SRC_CRX = 6;
  localparam int SRC_CTX = 7;
  localparam int SRC_SER2 = 8;
  localparam int SRC_EXT = 9;

  // codes as {pin5, pin4, pin3, pin2, pin1}, pin levels, low pins active
  localparam logic [NSRC-1:0][4:0] SRC_CODES = {
    5'h0e,  // external vector source (pin5 low)
    5'h17,  // second serial unit, vector 70
    5'h1b,  // console transmit, vector 64
    5'h13,  // console receive, vector 60
    5'h15,  // backplane vector register, vector 130
    5'h1d,  // dual port c, vector 134
    5'h19,  // dual port b, vector 124
    5'h11,  // dual port a, vector 120
    5'h1a,  // timer counter, vector 104
    5'h12   // line clock tick, vector 100
  };
  localparam logic [4:0] CODE_IDLE = 5'h1f;

  // sources held in set/clear latches, and the shared console clear
  localparam logic [NSRC-1:0] LATCHED_MASK = 10'h13f;
  localparam logic [NSRC-1:0] CONSOLE_MASK = 10'h0c0;

  // transitions of the four-slip burst
  localparam int SLIP_FOUR_EDGES = 4;
  localparam int SLIP_CNT_W = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ONE = 3'b001,
    ST_FOUR = 3'b010,
    ST_MULTI = 3'b011,
    ST_HOLD = 3'b100
  } ies_slip_t;

endpackage : ies_pkg

// >>> hw/ies_sync.sv
// two-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ps
module ies_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  if (WIDTH < 1) begin : gBadWidth
    $error("ies_sync needs WIDTH of at least 1");
  end

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stab_r;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_r <= '0;
      stab_r <= '0;
    end else begin
      meta_r <= din;
      stab_r <= meta_r;
    end
  end

  assign dout = stab_r;

endmodule : ies_sync

// >>> hw/ies_core.sv
// processor interrupt encoder, acknowledge decoder and ready slip logic
// Summary of operation
// R1 - seven latched sources, two logic latches, twelve capture latches
// R2 - lowest interrupt pin carries dma request unencoded
// R3 - interrupt pins one to four come from priority encoder
// R4 - pin five low when encoder selects an external vector source
// R5 - pin six is power fail or backplane reset or init
// R6 - pin seven is halt or console break, restart trap
// R7 - acknowledge shows code on bus bits 12-8, decoded from 12-8
// R8 - level six codes: line clock 100, timer counter 104
// R9 - level five codes: vectors 120, 124, 134, 130
// R10 - level four codes: console receive 60, transmit 64, serial 70
// R11 - processor acknowledges only highest pending above its priority
// R12 - sixteen sources, mixed polarities, two ORed groups
// R13 - seven sources held in latches until explicitly cleared
// R14 - column strobe captures requests; priority-in enables encoder output
// R15 - acknowledge start decodes code, pulses low clear for served source
// R16 - console receive and transmit share one clear output
// R17 - ready pulsed low during row strobe slips processor cycles
// R18 - slips only with no two-port, ack, timeout, grant; row strobe on
// R19 - single slip on priority-in with clock rise, or dma access
// R20 - single slip ends once priority-in drops
// R21 - dma select with slip one: four ready transitions then high
// R22 - both slip lines: pulse per clock rise until two-port ready
// R23 - restart clear needs no grant, read cycle and priority-in
// R24 - reset clears latches, counters; ready high, interrupts idle
`timescale 1ns/1ps
module ies_core import ies_pkg::*; #(
  parameter int SLIP_EDGES = SLIP_FOUR_EDGES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // latched request sources
  input wire logic lineClockTickRequest,
  input wire logic timerCounterRequest,
  input wire logic dualPortRequestA,
  input wire logic dualPortRequestB,
  input wire logic dualPortRequestC,
  input wire logic backplaneVectorRegRequest,
  input wire logic secondSerialRequest,
  // five-input logic circuit
  input wire logic backplaneHaltRequest,
  input wire logic consoleBreakRequest,
  input wire logic powerLossWarning,
  input wire logic backplaneResetRequest,
  input wire logic backplaneInitInput,
  // direct sources
  input wire logic consoleReceiveRequest_n,
  input wire logic consoleTransmitRequest_n,
  input wire logic parallelTimerChipRequest_n,
  input wire logic dmaControllerRequest_n,
  // processor bus
  input wire logic bufferedColumnStrobe_n,
  input wire logic rowStrobe_n,
  input wire logic localDataStrobe_n,
  input wire logic priorityInStrobe,
  input wire logic processorClockOutput,
  input wire logic cpuWrite_n,
  input wire logic acknowledgeTransaction,
  input wire logic grantSelectZero,
  input wire logic grantSelectOne,
  input wire logic [15:0] localAddressDataBus,
  // slip control
  input wire logic slipOneSelect_n,
  input wire logic slipFourSelect_n,
  input wire logic dmaControllerSelect_n,
  input wire logic dualPortReady_n,
  input wire logic externalAckActive_n,
  input wire logic timeoutRequest_n,
  input wire logic slowPeriphSelect,
  // processor interrupt pins
  output logic dmaRequestInput_n,
  output logic [3:0] codedRequestBit_n,
  output logic externalVectorFlagInput_n,
  output logic powerfailRequestInput_n,
  output logic restartRequestInput_n,
  // clears and ready
  output logic [NSRC-1:0] sourceAck_n,
  output logic consoleAck_n,
  output logic restartClear,
  output logic ready
);

  if (SLIP_EDGES < 2 || SLIP_EDGES > 7) begin : gBadEdges
    $error("SLIP_EDGES must lie in 2..7");
  end

  localparam int NIN = 37;
  // active-low pins are inverted around the synchroniser so that its reset
  // value is the idle level and no false edge follows reset
  localparam logic [NIN-1:0] IDLE_HIGH = 37'h001fc807e;
  localparam logic [SLIP_CNT_W-1:0] EDGE_LAST =
    SLIP_CNT_W'(SLIP_EDGES - 1);

  function automatic logic [4:0] encodeReq(input logic [NSRC-1:0] req);
    logic [4:0] code;
    code = CODE_IDLE;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        code = SRC_CODES[i];
      end
    end
    return code;
  endfunction : encodeReq

  function automatic logic [NSRC-1:0] decodeAck(input logic [4:0] code);
    logic [NSRC-1:0] hit;
    hit = '0;
    for (int i = 0; i < NSRC; i++) begin
      hit[i] = (code[3:0] == SRC_CODES[i][3:0]) &&
               (code[4] == SRC_CODES[i][4]);
    end
    return hit;
  endfunction : decodeAck

  // every pin is asynchronous to core_clk
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] syncIn;
  logic sLine, sTimer, sDpA, sDpB, sDpC, sBvr, sSer2;
  logic sHalt, sBreak, sPfail, sBreset, sInit;
  logic sRxN, sTxN, sParN, sDmaN;
  logic sCasN, sRasN, sIdsN, sPi, sCout, sWrN, sAck, sSel0, sSel1;
  logic [4:0] sBus;
  logic sSlip1N, sSlip4N, sDtcN, sDprdyN, sEiakN, sRqtmN, sSlow;

  assign rawIn = {lineClockTickRequest, timerCounterRequest,
    dualPortRequestA, dualPortRequestB, dualPortRequestC,
    backplaneVectorRegRequest, secondSerialRequest,
    backplaneHaltRequest, consoleBreakRequest, powerLossWarning,
    backplaneResetRequest, backplaneInitInput,
    consoleReceiveRequest_n, consoleTransmitRequest_n,
    parallelTimerChipRequest_n, dmaControllerRequest_n,
    bufferedColumnStrobe_n, rowStrobe_n, localDataStrobe_n,
    priorityInStrobe, processorClockOutput, cpuWrite_n,
    acknowledgeTransaction, grantSelectZero, grantSelectOne,
    localAddressDataBus[12:8],
    slipOneSelect_n, slipFourSelect_n, dmaControllerSelect_n,
    dualPortReady_n, externalAckActive_n, timeoutRequest_n,
    slowPeriphSelect} ^ IDLE_HIGH;

  ies_sync #(.WIDTH(NIN)) uSync (
    .core_clk(core_clk),
    .srst(srst),
    .din(rawIn),
    .dout(syncIn)
  );

  assign {sLine, sTimer, sDpA, sDpB, sDpC, sBvr, sSer2,
    sHalt, sBreak, sPfail, sBreset, sInit,
    sRxN, sTxN, sParN, sDmaN,
    sCasN, sRasN, sIdsN, sPi, sCout, sWrN, sAck, sSel0, sSel1,
    sBus, sSlip1N, sSlip4N, sDtcN, sDprdyN, sEiakN, sRqtmN,
    sSlow} = syncIn ^ IDLE_HIGH;

  // state
  logic [NSRC-1:0] srcPrev_r, srcLatch_r, codedCap_r;
  logic casPrev_r, coutPrev_r, ackPrev_r, rsPrev_r;
  logic pfLatch_r, rsLatch_r, pfCap_r, rsCap_r;
  logic dmaOut_r, restartClear_r, consoleAck_r, ready_r;
  logic [4:0] codeOut_r;
  logic [NSRC-1:0] sourceAck_r;
  logic [SLIP_CNT_W-1:0] slipCnt_r, slipCnt_nxt;
  ies_slip_t state_r, state_nxt;
  logic ready_nxt;

  // source levels, all active high, index order as the codes
  wire [NSRC-1:0] srcLevel = {~sParN, sSer2, ~sTxN, ~sRxN, sBvr, // R12
    sDpC, sDpB, sDpA, sTimer, sLine};
  wire casFall = ~sCasN & casPrev_r;
  wire coutRise = sCout & ~coutPrev_r;
  wire ackRise = sAck & ~ackPrev_r;
  wire [NSRC-1:0] latRise = srcLevel & ~srcPrev_r & LATCHED_MASK;
  wire [NSRC-1:0] ackHit = ackRise ? decodeAck(sBus) : '0; // R7 R15
  // set wins over a clear landing in the same cycle
  wire [NSRC-1:0] srcLatch_nxt = latRise | (srcLatch_r & ~ackHit); // R13
  wire [NSRC-1:0] pending = (srcLatch_r & LATCHED_MASK) |
    (srcLevel & ~LATCHED_MASK);
  wire [4:0] encCode = encodeReq(codedCap_r); // R3 R8 R9 R10
  wire pfSet = sPfail | sBreset | sInit; // R5
  wire pfLatch_nxt = pfSet | (pfLatch_r & ~(sPi & pfCap_r));
  wire rsSet = sHalt | sBreak; // R6
  wire rsLatch_nxt = (rsSet & ~rsPrev_r) | (rsLatch_r & ~restartClear_r);
  wire restartClear_nxt = ~sSel0 & ~sSel1 & sWrN & sPi & rsCap_r; // R23

  // slip qualifiers
  wire slipAllow = sDprdyN & sEiakN & sRqtmN & ~sSel0 & ~sSel1 & // R18
    ~sRasN;
  wire multiReq = ~sSlip1N & ~sSlip4N; // R22
  wire fourReq = ~sDtcN & ~sSlip1N & sSlip4N & ~sIdsN; // R21
  wire oneReq = (sSlow & sPi & coutRise) | (casFall & ~sDtcN); // R19

  always_ff @(posedge core_clk) begin
    if (srst) begin // R24
      srcPrev_r <= '0;
      srcLatch_r <= '0;
      codedCap_r <= '0;
      casPrev_r <= 1'b0;
      coutPrev_r <= 1'b0;
      ackPrev_r <= 1'b0;
      rsPrev_r <= 1'b0;
    end else begin
      srcPrev_r <= srcLevel;
      srcLatch_r <= srcLatch_nxt;
      casPrev_r <= ~sCasN;
      coutPrev_r <= sCout;
      ackPrev_r <= sAck;
      rsPrev_r <= rsSet;
      if (casFall) begin
        codedCap_r <= pending; // R1 R14
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin // R24
      pfLatch_r <= 1'b0;
      rsLatch_r <= 1'b0;
      pfCap_r <= 1'b0;
      rsCap_r <= 1'b0;
      restartClear_r <= 1'b0;
    end else begin
      pfLatch_r <= pfLatch_nxt;
      rsLatch_r <= rsLatch_nxt;
      restartClear_r <= restartClear_nxt;
      if (casFall) begin
        pfCap_r <= pfLatch_r; // R1
        rsCap_r <= rsLatch_r;
      end
    end
  end

  // the encoder drives a code only while priority-in is up
  always_ff @(posedge core_clk) begin
    if (srst) begin // R24
      codeOut_r <= CODE_IDLE;
      dmaOut_r <= 1'b0;
      sourceAck_r <= '1;
      consoleAck_r <= 1'b1;
    end else begin
      codeOut_r <= sPi ? encCode : CODE_IDLE; // R14 R4
      dmaOut_r <= ~sDmaN; // R2
      sourceAck_r <= ~ackHit; // R15
      consoleAck_r <= ~(|(ackHit & CONSOLE_MASK)); // R16
    end
  end

  // ready slip sequencer
  always_comb begin
    state_nxt = state_r;
    ready_nxt = ready_r;
    slipCnt_nxt = slipCnt_r;
    case (state_r)
      ST_IDLE: begin
        ready_nxt = 1'b1;
        if (slipAllow && multiReq && coutRise) begin // R22
          state_nxt = ST_MULTI;
          ready_nxt = 1'b0;
        end else if (slipAllow && fourReq && coutRise) begin // R21
          state_nxt = ST_FOUR;
          ready_nxt = 1'b0;
          slipCnt_nxt = SLIP_CNT_W'(1);
        end else if (slipAllow && oneReq) begin // R17 R19
          state_nxt = ST_ONE;
          ready_nxt = 1'b0;
        end
      end
      ST_ONE: begin
        if (!sPi) begin // R20
          state_nxt = ST_IDLE;
          ready_nxt = 1'b1;
        end
      end
      ST_FOUR: begin
        if (!slipAllow) begin
          state_nxt = ST_HOLD;
          ready_nxt = 1'b1;
        end else if (coutRise) begin
          slipCnt_nxt = slipCnt_r + SLIP_CNT_W'(1);
          ready_nxt = ~ready_r;
          if (slipCnt_r == EDGE_LAST) begin // R21
            state_nxt = ST_HOLD;
            ready_nxt = 1'b1;
          end
        end
      end
      ST_MULTI: begin
        if (!slipAllow) begin // R22
          state_nxt = ST_HOLD;
          ready_nxt = 1'b1;
        end else begin
          ready_nxt = ~coutRise;
        end
      end
      ST_HOLD: begin
        ready_nxt = 1'b1;
        if (sRasN && sIdsN) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        ready_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin // R24
      state_r <= ST_IDLE;
      ready_r <= 1'b1;
      slipCnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      slipCnt_r <= slipCnt_nxt;
    end
  end

  assign dmaRequestInput_n = ~dmaOut_r;
  assign codedRequestBit_n = codeOut_r[3:0];
  assign externalVectorFlagInput_n = codeOut_r[4];
  assign powerfailRequestInput_n = ~pfCap_r;
  assign restartRequestInput_n = ~rsCap_r;
  assign sourceAck_n = sourceAck_r;
  assign consoleAck_n = consoleAck_r;
  assign restartClear = restartClear_r;
  assign ready = ready_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  dma_pass_a: assert property (dmaRequestInput_n == ~$past(~sDmaN)) // R2
    else $error("dma pin does not follow synced request");
  code_idle_a: assert property (!$past(sPi) |-> // R14
    codedRequestBit_n == 4'hf && externalVectorFlagInput_n)
    else $error("code driven without priority-in");
  ext_vec_a: assert property ($past(sPi) && $past(codedCap_r) == // R4
    10'h200 |-> !externalVectorFlagInput_n)
    else $error("external source did not pull pin five low");
  pf_latch_a: assert property (pfSet |=> pfLatch_r) // R5
    else $error("power fail latch missed a request");
  rs_pin_a: assert property (casFall ##1 1'b1 |-> // R6
    restartRequestInput_n == ~$past(rsLatch_r))
    else $error("restart pin not captured on column strobe");
  rs_clear_a: assert property (restartClear |-> // R23
    $past(~sSel0 & ~sSel1 & sWrN & sPi))
    else $error("restart clear outside a granted-free read");
  ack_clear_a: assert property (ackRise && ackHit[SRC_RTC] // R15
    |=> !sourceAck_n[SRC_RTC] ##1 sourceAck_n[SRC_RTC])
    else $error("acknowledge clear is not a one-cycle low");
  con_ack_a: assert property (!consoleAck_n |-> // R16
    $past(ackHit[SRC_CRX] | ackHit[SRC_CTX]))
    else $error("console clear without a console acknowledge");
  slip_gate_a: assert property ($fell(ready) |-> $past(slipAllow)) // R18
    else $error("ready fell while slips were barred");
  one_end_a: assert property (state_r == ST_ONE && !sPi |=> ready) // R20
    else $error("single slip did not release ready");
  four_cnt_a: assert property (state_r == ST_FOUR |-> // R21
    slipCnt_r <= SLIP_CNT_W'(SLIP_EDGES))
    else $error("four-slip burst overran its transitions");

  one_slip_c: cover property (state_r == ST_IDLE ##1 state_r == ST_ONE);
  four_done_c: cover property (state_r == ST_FOUR ##1 state_r == ST_HOLD);
  multi_c: cover property (state_r == ST_MULTI ##1 state_r == ST_HOLD);
  ack_c: cover property (!consoleAck_n);

endmodule : ies_core

// >>> dv/ies_cpu_model.sv
// processor model: column strobe, priority-in read and acknowledge
`timescale 1ns/1ps
module ies_cpu_model (
  // clock
  input wire logic core_clk,
  // interrupt pins from the block
  input wire logic [3:0] codedRequestBit_n,
  input wire logic externalVectorFlagInput_n,
  input wire logic powerfailRequestInput_n,
  input wire logic restartRequestInput_n,
  // bus strobes and data
  output logic columnStrobe_n,
  output logic priorityIn,
  output logic ackTxn,
  output logic [15:0] busData,
  // pins as read by the processor
  output logic [6:0] seenPins,
  output logic seenStb
);
  logic [6:0] p;

  initial begin
    columnStrobe_n <= 1'b1;
    priorityIn <= 1'b0;
    ackTxn <= 1'b0;
    busData <= 16'ha5a5;
    seenPins <= 7'h7f;
    seenStb <= 1'b0;
  end

  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : waitc

  task automatic setPi(input logic v);
    @(posedge core_clk);
    priorityIn <= v;
  endtask : setPi

  // one interrupt read; status word priority is zero, so any coded level
  // is above it and the highest pending one is acknowledged
  task automatic serve(input bit chk);
    @(posedge core_clk);
    columnStrobe_n <= 1'b0;
    waitc(6);
    priorityIn <= 1'b1;
    waitc(6);
    p = {restartRequestInput_n, powerfailRequestInput_n,
         externalVectorFlagInput_n, codedRequestBit_n};
    seenPins <= p;
    seenStb <= chk;
    waitc(1);
    seenStb <= 1'b0;
    if (p[4:0] != 5'h1f) begin
      busData <= {3'h0, p[4:0], 8'h00};
      waitc(1);
      ackTxn <= 1'b1;
      waitc(6);
      ackTxn <= 1'b0;
      waitc(1);
      // released bus no longer shows the code
      busData <= ~busData;
    end
    waitc(1);
    priorityIn <= 1'b0;
    columnStrobe_n <= 1'b1;
    waitc(4);
  endtask : serve
endmodule : ies_cpu_model

// >>> dv/tb.sv
// testbench: encoder, acknowledge decoder and ready slips
`timescale 1ns/1ps
module tb import ies_pkg::*;;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [NSRC-1:0] reqs;
  logic [4:0] nmi;
  logic dmaReq_n;
  logic row_n, ds_n, cout, wr_n;
  logic g0, g1, slow, dsel_n;
  logic slip1_n, slip4_n, dpr_n;
  logic eak_n, tmo_n;
  logic dmaPin_n, vec_n, pf_n, rs_n, conAck_n, rsClr, ready;
  logic [3:0] code_n;
  logic [NSRC-1:0] srcAck_n;
  logic cas_n, pi, ack, seenStb, prevReady;
  logic [15:0] bus;
  logic [6:0] seenPins;
  logic [6:0] codeQ[$];
  logic [NSRC:0] ackQ[$];
  int readyQ[$];
  int miscompares = 0, n_checks = 0, falls = 0;
  int seed = 53061;
  int lst[7] = '{0, 1, 2, 3, 4, 5, 8};
  bit win = 1'b0;

  always #2.5 core_clk = ~core_clk;

  ies_core i_dut (.core_clk(core_clk), .srst(srst),
    .lineClockTickRequest(reqs[0]), .timerCounterRequest(reqs[1]),
    .dualPortRequestA(reqs[2]), .dualPortRequestB(reqs[3]),
    .dualPortRequestC(reqs[4]), .backplaneVectorRegRequest(reqs[5]),
    .secondSerialRequest(reqs[8]), .backplaneHaltRequest(nmi[0]),
    .consoleBreakRequest(nmi[1]), .powerLossWarning(nmi[2]),
    .backplaneResetRequest(nmi[3]), .backplaneInitInput(nmi[4]),
    .consoleReceiveRequest_n(~reqs[6]),
    .consoleTransmitRequest_n(~reqs[7]),
    .parallelTimerChipRequest_n(~reqs[9]),
    .dmaControllerRequest_n(dmaReq_n), .bufferedColumnStrobe_n(cas_n),
    .rowStrobe_n(row_n), .localDataStrobe_n(ds_n),
    .priorityInStrobe(pi), .processorClockOutput(cout),
    .cpuWrite_n(wr_n), .acknowledgeTransaction(ack),
    .grantSelectZero(g0), .grantSelectOne(g1),
    .localAddressDataBus(bus), .slipOneSelect_n(slip1_n),
    .slipFourSelect_n(slip4_n), .dmaControllerSelect_n(dsel_n),
    .dualPortReady_n(dpr_n), .externalAckActive_n(eak_n),
    .timeoutRequest_n(tmo_n), .slowPeriphSelect(slow),
    .dmaRequestInput_n(dmaPin_n), .codedRequestBit_n(code_n),
    .externalVectorFlagInput_n(vec_n), .powerfailRequestInput_n(pf_n),
    .restartRequestInput_n(rs_n), .sourceAck_n(srcAck_n),
    .consoleAck_n(conAck_n), .restartClear(rsClr), .ready(ready));

  ies_cpu_model i_cpu (.core_clk(core_clk), .codedRequestBit_n(code_n),
    .externalVectorFlagInput_n(vec_n), .powerfailRequestInput_n(pf_n),
    .restartRequestInput_n(rs_n), .columnStrobe_n(cas_n),
    .priorityIn(pi), .ackTxn(ack), .busData(bus),
    .seenPins(seenPins), .seenStb(seenStb));

  task automatic cmpV(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpV

  task automatic cmpN(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      miscompares++;
      $display("mismatch at %0t: %0d ready falls, %0d expected", $time,
               got, exp);
    end
  endtask : cmpN

  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // note expected code and clear, then let the processor serve it
  task automatic serveOne(input int idx);
    logic [NSRC:0] a;
    a = '1;
    a[idx] = 1'b0;
    a[NSRC] = !CONSOLE_MASK[idx];
    codeQ.push_back({2'b11, SRC_CODES[idx]});
    ackQ.push_back(a);
    i_cpu.serve(1'b1);
  endtask : serveOne

  // count ready falls over n processor clock pulses
  task automatic slipWin(input int n, input int exp, input bit dropPi);
    win <= 1'b1;
    repeat (n) begin
      cyc(4);
      cout <= 1'b1;
      cyc(4);
      cout <= 1'b0;
    end
    if (dropPi)
      i_cpu.setPi(1'b0);
    cyc(6);
    win <= 1'b0;
    readyQ.push_back(exp);
    cyc(3);
    cmpV(ready, 16'h1);
  endtask : slipWin

  always @(posedge core_clk) begin
    if (seenStb === 1'b1)
      cmpV(seenPins, codeQ.size() ? codeQ.pop_front() : 16'hffff);
    if (!srst && {conAck_n, srcAck_n} !== '1)
      cmpV({conAck_n, srcAck_n}, ackQ.size() ? ackQ.pop_front() : '1);
    if (win && prevReady === 1'b1 && ready === 1'b0)
      falls++;
    if (!win && readyQ.size() > 0) begin
      cmpN(falls, readyQ.pop_front());
      falls = 0;
    end
    prevReady = ready;
  end

  initial begin
    int i, j;
    reqs <= '0;
    nmi <= '0;
    dmaReq_n <= 1'b1;
    row_n <= 1'b1;
    ds_n <= 1'b1;
    cout <= 1'b0;
    wr_n <= 1'b1;
    g0 <= 1'b0;
    g1 <= 1'b0;
    slow <= 1'b0;
    dsel_n <= 1'b1;
    slip1_n <= 1'b1;
    slip4_n <= 1'b1;
    dpr_n <= 1'b1;
    eak_n <= 1'b1;
    tmo_n <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    cyc(4);
    cmpV({rs_n, pf_n, vec_n, code_n, dmaPin_n, ready, rsClr}, 16'h3fe);
    for (int k = 0; k < NSRC; k++) begin
      reqs[k] <= 1'b1;
      cyc(4);
      if (LATCHED_MASK[k])
        reqs[k] <= 1'b0;
      cyc(3);
      serveOne(k);
      reqs[k] <= 1'b0;
      cyc(4);
    end
    repeat (6) begin
      i = $unsigned($random(seed)) % 7;
      j = $unsigned($random(seed)) % 7;
      if (i == j)
        j = (i + 1) % 7;
      reqs[lst[i]] <= 1'b1;
      reqs[lst[j]] <= 1'b1;
      cyc(4);
      reqs <= '0;
      cyc(3);
      serveOne(lst[i < j ? i : j]);
      serveOne(lst[i < j ? j : i]);
    end
    for (int k = 0; k < 3; k++) begin
      // write cycle: restart must survive the read
      nmi <= (5'b00100 << k) | (5'b00001 << (k % 2));
      dmaReq_n <= 1'b0;
      wr_n <= 1'b0;
      cyc(4);
      nmi[1:0] <= 2'b00;
      cyc(3);
      cmpV(dmaPin_n, 16'h0);
      codeQ.push_back(7'h1f);
      i_cpu.serve(1'b1);
      nmi <= '0;
      dmaReq_n <= 1'b1;
      wr_n <= 1'b1;
      i_cpu.serve(1'b0);
      codeQ.push_back(7'h7f);
      i_cpu.serve(1'b1);
    end
    row_n <= 1'b0;
    slow <= 1'b1;
    i_cpu.setPi(1'b1);
    slipWin(1, 1, 1'b1);
    slow <= 1'b0;
    dsel_n <= 1'b0;
    slip1_n <= 1'b0;
    ds_n <= 1'b0;
    slipWin(6, 2, 1'b0);
    dsel_n <= 1'b1;
    ds_n <= 1'b1;
    row_n <= 1'b1;
    slip4_n <= 1'b0;
    cyc(4);
    row_n <= 1'b0;
    slipWin(5, 5, 1'b0);
    dpr_n <= 1'b0;
    slipWin(3, 0, 1'b0);
    dpr_n <= 1'b1;
    // leave the hold state so that only the barred gate stops the slips
    row_n <= 1'b1;
    cyc(4);
    for (int k = 0; k < 5; k++) begin
      g0 <= (k == 0);
      g1 <= (k == 1);
      eak_n <= (k != 2);
      tmo_n <= (k != 3);
      row_n <= (k == 4);
      slipWin(3, 0, 1'b0);
    end
    for (int t = 0; t < 100 && codeQ.size() + ackQ.size() > 0; t++)
      cyc(1);
    if (codeQ.size() + ackQ.size() + readyQ.size() > 0) begin
      miscompares++;
      $display("mismatch at %0t: expected results never seen", $time);
    end
    results();
  end
endmodule : tb
